// >>> rtl/btm_pkg.sv
// Constants and types shared by the bus transceiver mode control block.
// Assumes a single 10 MHz clock and a classic Wishbone register port.
package btm_pkg;

    localparam int CLK_HZ         = 10_000_000;
    localparam int CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;

    // Activity and idle detection times (plain defaults).
    localparam int T_DET_ACT_NS   = 500;
    localparam int T_DET_IDLE_NS  = 2000;
    localparam int ACT_CYCLES     = (T_DET_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_CYCLES    = (T_DET_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W          = 8;

    // Register map, byte addresses.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;

    // Control register fields and reset value.
    localparam int CTRL_SW_STBY_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Status register field positions.
    localparam int ST_MODE_LSB  = 0;
    localparam int ST_POWER_ON_FLAG_BIT  = 2;
    localparam int ST_UVCC_BIT  = 3;
    localparam int ST_UVIO_BIT  = 4;
    localparam int ST_WAKE_BIT  = 5;
    localparam int ST_TX_BIT    = 6;
    localparam int ST_ACT_BIT   = 7;

    // Pin input order and levels after reset (pull-ups and pull-downs).
    localparam int PIN_W = 6;
    localparam int P_TXD = 0;
    localparam int P_TRANSMIT_ENABLE_N_N = 1;
    localparam int P_GE = 2;
    localparam int P_STBY_N = 3;
    localparam int P_SCLK = 4;
    localparam int P_SSEL_N = 5;
    localparam logic [PIN_W-1:0] PIN_INIT = 6'h32;

    // Monitor input order.
    localparam int MON_W = 9;
    localparam int M_POR = 0;
    localparam int M_UVCC = 1;
    localparam int M_UVIO = 2;
    localparam int M_OT = 3;
    localparam int M_TXTO = 4;
    localparam int M_ACT = 5;
    localparam int M_LOW = 6;
    localparam int M_WAKE = 7;
    localparam int M_ERR = 8;
    localparam logic [MON_W-1:0] MON_INIT = 9'h006;

    typedef enum logic [1:0] {
        BTM_OFF  = 2'h0,
        BTM_STBY = 2'h1,
        BTM_NORM = 2'h2
    } btm_mode_t;

endpackage

// >>> rtl/btm_sync.sv
// Three-stage input synchroniser with agreement filter for a group of bits.
// Assumes inputs are asynchronous to clk_i; output is registered.
`timescale 1ns/10ps
module btm_sync
#(
    parameter int                WIDTH = 1,
    parameter logic [WIDTH-1:0]  INIT  = '0
)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    wire  [WIDTH-1:0] next_q = (s2 & s3) | (q_o & (s2 ^ s3));

    // A change is taken only once the second and third stages agree.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1  <= INIT;
            s2  <= INIT;
            s3  <= INIT;
            q_o <= INIT;
        end
        else
        begin
            s1  <= d_i;
            s2  <= s1;
            s3  <= s2;
            q_o <= next_q;
        end
    end
endmodule

// >>> rtl/btm_mode_ctrl.sv
// Mode, transmitter gating and receive pin control of a bus transceiver.
// Assumes analog comparators deliver supply, bus and wake results as levels.
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module btm_mode_ctrl
    import btm_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Host pins
    input  wire logic        txd_i,
    input  wire logic        transmit_enable_n_i,
    input  wire logic        guardian_enable_i,
    input  wire logic        standby_n_i,
    input  wire logic        serial_clk_i,
    input  wire logic        serial_select_n_i,
    output logic             receive_data_out_o,
    output logic             error_indicator_n_o,
    output logic             error_indicator_oe_o,
    // Analog monitor results
    input  wire logic        por_ok_i,
    input  wire logic        core_uv_i,
    input  wire logic        io_uv_i,
    input  wire logic        overtemp_i,
    input  wire logic        transmit_enable_n_timeout_i,
    input  wire logic        bus_act_i,
    input  wire logic        bus_low_i,
    input  wire logic        wake_event_i,
    input  wire logic        error_flag_i,
    // Bus driver and analog enables
    output logic             bus_line_plus_o,
    output logic             bus_line_minus_o,
    output logic             bus_drive_en_o,
    output logic             normal_rx_en_o,
    output logic             lp_rx_en_o,
    output logic             uv_det_en_o,
    // Serial readout side
    output logic             serial_readout_ok_o,
    output logic             serial_clk_int_o,
    output logic             serial_select_n_int_o
);
    logic [PIN_W-1:0] pin_s;
    logic [MON_W-1:0] mon_s;

    // Pins and monitors pass the filter first.
    btm_sync #(.WIDTH(PIN_W), .INIT(PIN_INIT)) u_pin_sync
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({serial_select_n_i, serial_clk_i, standby_n_i,
                 guardian_enable_i, transmit_enable_n_i, txd_i}),
        .q_o   (pin_s)
    );

    btm_sync #(.WIDTH(MON_W), .INIT(MON_INIT)) u_mon_sync
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({error_flag_i, wake_event_i, bus_low_i, bus_act_i, transmit_enable_n_timeout_i,
                 overtemp_i, io_uv_i, core_uv_i, por_ok_i}),
        .q_o   (mon_s)
    );

    btm_mode_t  mode;
    btm_mode_t  next_mode;
    logic       power_on_flag;
    logic       core_supply_undervoltage_flag;
    logic       io_supply_undervoltage_flag;
    logic       wake_flag;
    logic       wake_hold;
    logic       power_on_flag_clr_pend;
    logic       tx_on;
    logic       bus_active;
    logic [CNT_W-1:0] act_cnt;
    logic [CNT_W-1:0] idle_cnt;
    logic [31:0] ctrl;

    // Undervoltage on the io supply forces safe internal levels.
    wire uv_io       = io_supply_undervoltage_flag;
    wire uv_cc       = core_supply_undervoltage_flag;
    wire txd_int     = pin_s[P_TXD] & ~uv_io;
    wire transmit_enable_n_n_int  = pin_s[P_TRANSMIT_ENABLE_N_N] | uv_io;
    wire ge_int      = pin_s[P_GE] & ~uv_io;
    wire stby_n_int  = pin_s[P_STBY_N] & ~uv_io & ~ctrl[CTRL_SW_STBY_BIT];
    wire sclk_int    = pin_s[P_SCLK] | uv_io;
    wire ssel_n_int  = pin_s[P_SSEL_N] | uv_io;
    wire por_int     = mon_s[M_POR];

    wire in_norm     = (mode == BTM_NORM);
    wire in_stby     = (mode == BTM_STBY);
    wire in_off      = (mode == BTM_OFF);

    // Mode decisions.
    wire go_off      = ~por_int & ~in_off;
    wire go_stby_up  = in_off & por_int;
    wire go_norm     = in_stby & stby_n_int & ~uv_io & ~uv_cc;
    wire leave_norm  = in_norm & (~stby_n_int | uv_io | uv_cc);

    always_comb
    begin
        next_mode = mode;
        if (go_off)
            next_mode = BTM_OFF;
        else if (go_stby_up)
            next_mode = BTM_STBY;
        else if (go_norm)
            next_mode = BTM_NORM;
        else if (leave_norm)
            next_mode = BTM_STBY;
    end

    // Wake flag: set only in Standby without core undervoltage.
    wire wake_set     = in_stby & ~uv_cc & mon_s[M_WAKE];
    wire next_wake    = wake_set | (wake_flag & ~go_norm);

    // Transmitter gating in Normal mode only; guardian enable is ignored elsewhere.
    wire tx_allowed   = in_norm & ge_int & ~transmit_enable_n_n_int & ~mon_s[M_OT] & ~mon_s[M_TXTO];
    // Activation waits for the first low on transmit data.
    // Leaving Normal drops tx_on at the same edge; the registered driver outputs stay on for the first Standby cycle.
    wire next_tx_on   = tx_allowed & (next_mode == BTM_NORM) & (tx_on | ~txd_int);

    // Activity and idle detection counters.
    wire bus_act_int  = mon_s[M_ACT];
    wire act_done     = (act_cnt == CNT_W'(ACT_CYCLES - 1));
    wire idle_done    = (idle_cnt == CNT_W'(IDLE_CYCLES - 1));
    wire next_active  = in_norm & (bus_active ? ~(~bus_act_int & idle_done)
                                              : (bus_act_int & act_done));

    // Receive and error pin selection.
    wire norm_rxd     = bus_active ? ~mon_s[M_LOW] : 1'b1;
    wire next_rxd     = in_off ? 1'b1 :
                        in_norm ? norm_rxd :
                        uv_io  ? 1'b0 :
                        ~wake_hold;
    wire stby_err_sel = uv_cc & stby_n_int;
    wire next_error_indicator_n    = uv_io ? 1'b0 :
                        (in_norm | stby_err_sel) ? ~mon_s[M_ERR] :
                        ~wake_hold;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode <= BTM_OFF;
        else
            mode <= next_mode;
    end

    // Supply flags and the power-on flag.
    always_ff @(posedge clk_i)
    begin
        if (rst_i | in_off)
        begin
            power_on_flag                 <= 1'b0;
            core_supply_undervoltage_flag <= 1'b1;
            io_supply_undervoltage_flag   <= 1'b1;
            power_on_flag_clr_pend                 <= 1'b0;
        end
        else if (go_off)
        begin
            core_supply_undervoltage_flag <= 1'b1;
            io_supply_undervoltage_flag   <= 1'b1;
        end
        else
        begin
            core_supply_undervoltage_flag <= mon_s[M_UVCC];
            io_supply_undervoltage_flag   <= mon_s[M_UVIO];
            power_on_flag_clr_pend                 <= go_norm;
            if (power_on_flag_clr_pend)
                power_on_flag <= 1'b0;
        end
        if (!rst_i && go_stby_up)
            power_on_flag <= 1'b1;
    end

    // Digital section state, reset again on every power-up.
    always_ff @(posedge clk_i)
    begin
        if (rst_i | in_off)
        begin
            wake_flag  <= 1'b0;
            wake_hold  <= 1'b0;
            tx_on      <= 1'b0;
            bus_active <= 1'b0;
            act_cnt    <= '0;
            idle_cnt   <= '0;
        end
        else
        begin
            wake_flag  <= next_wake;
            if (!uv_cc)
                wake_hold <= next_wake;
            tx_on      <= next_tx_on;
            bus_active <= next_active;
            act_cnt    <= (in_norm & bus_act_int & ~act_done) ? act_cnt + 1'b1 : '0;
            idle_cnt   <= (in_norm & ~bus_act_int & ~idle_done) ? idle_cnt + 1'b1 : '0;
        end
    end

    // Registered pin and enable outputs.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            receive_data_out_o    <= 1'b1;
            error_indicator_n_o   <= 1'b1;
            error_indicator_oe_o  <= 1'b0;
            bus_line_plus_o       <= 1'b0;
            bus_line_minus_o      <= 1'b0;
            bus_drive_en_o        <= 1'b0;
            normal_rx_en_o        <= 1'b0;
            lp_rx_en_o            <= 1'b0;
            uv_det_en_o           <= 1'b0;
            serial_readout_ok_o   <= 1'b0;
            serial_clk_int_o      <= 1'b1;
            serial_select_n_int_o <= 1'b1;
        end
        else
        begin
            receive_data_out_o    <= next_rxd;
            error_indicator_n_o   <= next_error_indicator_n;
            error_indicator_oe_o  <= ~in_off;
            bus_line_plus_o       <= tx_on & txd_int;
            bus_line_minus_o      <= tx_on & ~txd_int;
            bus_drive_en_o        <= tx_on;
            normal_rx_en_o        <= in_norm;
            lp_rx_en_o            <= in_stby & ~uv_cc;
            uv_det_en_o           <= ~in_off;
            serial_readout_ok_o   <= ~in_off & ~uv_io;
            serial_clk_int_o      <= sclk_int;
            serial_select_n_int_o <= ssel_n_int;
        end
    end

    // Wishbone slave: one wait state, unmapped reads return zero.
    wire wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire sel_ctrl  = (wb_adr_i == REG_CTRL);
    wire sel_stat  = (wb_adr_i == REG_STATUS);
    wire [31:0] status_word = {24'h0, bus_active, tx_on, wake_flag,
                               io_supply_undervoltage_flag,
                               core_supply_undervoltage_flag,
                               power_on_flag, mode};
    wire [31:0] rd_word = sel_ctrl ? ctrl : sel_stat ? status_word : 32'h0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            ctrl     <= CTRL_RESET;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= (wb_req & ~wb_we_i) ? rd_word : 32'h0;
            if (wb_req & wb_we_i & sel_ctrl & wb_sel_i[0])
                ctrl[7:0] <= wb_dat_i[7:0];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_normal_enables;
        in_norm |=> normal_rx_en_o && uv_det_en_o && !lp_rx_en_o;
    endproperty
    a_normal_enables: assert property (p_normal_enables)
        else $error("Normal mode enables wrong");

    property p_tx_gated;
        (in_norm && (!ge_int || transmit_enable_n_n_int)) |=> ##1 !bus_drive_en_o;
    endproperty
    a_tx_gated: assert property (p_tx_gated)
        else $error("Transmitter driven while gated off");

    property p_tx_polarity;
        tx_on |=> bus_drive_en_o && (bus_line_plus_o == $past(txd_int))
                  && (bus_line_minus_o == !$past(txd_int));
    endproperty
    a_tx_polarity: assert property (p_tx_polarity)
        else $error("Bus polarity wrong");

    property p_tx_first_low;
        (!tx_on && tx_allowed && txd_int) |=> !tx_on;
    endproperty
    a_tx_first_low: assert property (p_tx_first_low)
        else $error("Transmitter started without low data");

    property p_stby_lp;
        in_stby |=> !bus_drive_en_o && !normal_rx_en_o && (lp_rx_en_o == !$past(uv_cc));
    endproperty
    a_stby_lp: assert property (p_stby_lp)
        else $error("Standby enables wrong");

    property p_off_quiet;
        in_off |=> receive_data_out_o && !error_indicator_oe_o && !lp_rx_en_o
                   && !bus_drive_en_o;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("Power-off outputs wrong");

    property p_por_drop;
        (!por_int && !in_off) |=> in_off;
    endproperty
    a_por_drop: assert property (p_por_drop)
        else $error("Did not revert to power-off");

    sequence s_enter_norm;
        in_stby ##1 in_norm;
    endsequence
    property p_enter_norm;
        s_enter_norm |-> ##1 !power_on_flag;
    endproperty
    a_enter_norm: assert property (p_enter_norm)
        else $error("Power-on flag not cleared after entry");

    property p_readout_block;
        (in_off || uv_io) |=> !serial_readout_ok_o;
    endproperty
    a_readout_block: assert property (p_readout_block)
        else $error("Readout allowed while refused");

    property p_io_safe;
        uv_io |-> !stby_n_int && !ge_int && !txd_int && transmit_enable_n_n_int
                  ##1 serial_clk_int_o && serial_select_n_int_o;
    endproperty
    a_io_safe: assert property (p_io_safe)
        else $error("Io undervoltage levels not forced");

    property p_idle_high;
        (in_norm && !bus_active) |=> receive_data_out_o;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("Receive pin not high while idle");

endmodule

// >>> tb/btm_host_model.sv
// Host-side model: protocol controller and guardian pin drivers.
// Assumes one bench process calls its tasks; pins change by NBA after a rising edge.
`timescale 1ns/10ps
module btm_host_model
(
    // Clock
    input  wire logic clk_i,
    // Host pins toward the transceiver
    output logic      txd_o,
    output logic      transmit_enable_n_o,
    output logic      guardian_enable_o,
    output logic      standby_n_o,
    output logic      serial_clk_o,
    output logic      serial_select_n_o
);
    // Serial pins rest at their idle levels until a test moves them.
    initial
    begin
        txd_o               = 1'b1;
        transmit_enable_n_o = 1'b1;
        guardian_enable_o   = 1'b0;
        standby_n_o         = 1'b0;
        serial_clk_o        = 1'b1;
        serial_select_n_o   = 1'b1;
    end

    task automatic request_mode(input logic normal);
        @(posedge clk_i);
        standby_n_o <= normal;
    endtask

    task automatic set_tx(input logic ge, input logic en_n, input logic d);
        @(posedge clk_i);
        guardian_enable_o   <= ge;
        transmit_enable_n_o <= en_n;
        txd_o               <= d;
    endtask

    task automatic set_serial(input logic c, input logic s);
        @(posedge clk_i);
        serial_clk_o      <= c;
        serial_select_n_o <= s;
    endtask
endmodule

// >>> tb/bus_transceiver_mode_control_bench.sv
// Self-checking bench for the transceiver mode control block.
// Assumes the host model drives the pins and the bench drives monitors and Wishbone.
`timescale 1ns/10ps
module bus_transceiver_mode_control_bench;
    import btm_pkg::*;
    localparam int CEIL = 20000;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]         wb_adr_i = 8'h00;
    logic [3:0]         wb_sel_i = 4'h0;
    logic [31:0]        wb_dat_i = 32'h0, wb_dat_o, rd;
    logic               wb_ack_o, h_txd, h_tx_en_n, h_ge, h_stby_n, h_ser_clk, h_ser_sel_n;
    logic [MON_W-1:0]   mon = MON_INIT;
    logic               rxd, err_pin_n, err_oe, plus, minus, drv, nrx, lprx, uvdet;
    logic               ro_ok, ser_clk_int, ser_sel_int;
    int                 fails = 0, n_compared = 0, cycles = 0;

    always #50 clk_i = ~clk_i;

    btm_host_model i_btm_host_model (.clk_i(clk_i), .txd_o(h_txd),
        .transmit_enable_n_o(h_tx_en_n), .guardian_enable_o(h_ge), .standby_n_o(h_stby_n),
        .serial_clk_o(h_ser_clk), .serial_select_n_o(h_ser_sel_n));

    btm_mode_ctrl i_btm_mode_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd_i(h_txd),
        .transmit_enable_n_i(h_tx_en_n), .guardian_enable_i(h_ge), .standby_n_i(h_stby_n),
        .serial_clk_i(h_ser_clk), .serial_select_n_i(h_ser_sel_n),
        .receive_data_out_o(rxd), .error_indicator_n_o(err_pin_n),
        .error_indicator_oe_o(err_oe), .por_ok_i(mon[M_POR]), .core_uv_i(mon[M_UVCC]),
        .io_uv_i(mon[M_UVIO]), .overtemp_i(mon[M_OT]), .transmit_enable_n_timeout_i(mon[M_TXTO]),
        .bus_act_i(mon[M_ACT]), .bus_low_i(mon[M_LOW]), .wake_event_i(mon[M_WAKE]),
        .error_flag_i(mon[M_ERR]), .bus_line_plus_o(plus), .bus_line_minus_o(minus),
        .bus_drive_en_o(drv), .normal_rx_en_o(nrx), .lp_rx_en_o(lprx), .uv_det_en_o(uvdet),
        .serial_readout_ok_o(ro_ok), .serial_clk_int_o(ser_clk_int),
        .serial_select_n_int_o(ser_sel_int));

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == CEIL)
        begin
            fails++;
            print_verdict();
        end
    end

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Classic single cycle; only the bench timeout ends a wait for ack.
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
        cmp_bit(wb_ack_o, 1'b0, "ack stands one cycle");
    endtask

    task automatic set_mon(input int idx, input logic v);
        @(posedge clk_i);
        mon[idx] <= v;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    function automatic logic [31:0] exp_st(input btm_mode_t m, input logic pw, input logic uc,
                                           input logic ui, input logic wk);
        logic [31:0] s;
        s = 32'h0;
        s[ST_MODE_LSB +: 2] = m;
        s[ST_POWER_ON_FLAG_BIT] = pw;
        s[ST_UVCC_BIT] = uc;
        s[ST_UVIO_BIT] = ui;
        s[ST_WAKE_BIT] = wk;
        return s;
    endfunction

    initial
    begin
        logic d;
        void'($urandom(32'h5C03));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(4);
        cmp_bit(rxd, 1'b1, "rxd off");
        cmp_bit(err_oe | nrx | lprx | drv, 1'b0, "all off");
        cmp_bit(ro_ok, 1'b0, "readout off");
        wb_xfer(1'b0, 8'h08, 32'h0);
        cmp_word(rd, 32'h0, "unmapped read");
        $display("test reset done");

        set_mon(M_POR, 1'b1);
        set_mon(M_WAKE, 1'b1);
        settle(8);
        wb_xfer(1'b0, REG_STATUS, 32'h0);
        cmp_word(rd, exp_st(BTM_STBY, 1'b1, 1'b1, 1'b1, 1'b0), "power-up status");
        cmp_bit(lprx, 1'b0, "lp rx under core uv");
        set_mon(M_WAKE, 1'b0);
        set_mon(M_UVIO, 1'b0);
        set_mon(M_UVCC, 1'b0);
        settle(8);
        wb_xfer(1'b0, REG_STATUS, 32'h0);
        cmp_word(rd, exp_st(BTM_STBY, 1'b1, 1'b0, 1'b0, 1'b0), "flags clear");
        cmp_bit(lprx & ~nrx, 1'b1, "standby receivers");
        i_btm_host_model.set_tx(1'b1, 1'b0, 1'b0);
        settle(8);
        cmp_bit(drv, 1'b0, "guardian ignored");
        set_mon(M_WAKE, 1'b1);
        settle(2);
        set_mon(M_WAKE, 1'b0);
        settle(8);
        cmp_bit(rxd | err_pin_n, 1'b0, "wake shown");
        set_mon(M_UVCC, 1'b1);
        settle(8);
        cmp_bit(rxd | err_pin_n, 1'b0, "wake held");
        cmp_bit(lprx, 1'b0, "lp rx off");
        set_mon(M_UVCC, 1'b0);
        $display("test standby done");

        i_btm_host_model.set_tx(1'b1, 1'b0, 1'b1);
        i_btm_host_model.request_mode(1'b1);
        settle(8);
        wb_xfer(1'b0, REG_STATUS, 32'h0);
        cmp_word(rd, exp_st(BTM_NORM, 1'b0, 1'b0, 1'b0, 1'b0), "normal entry");
        cmp_bit(nrx & uvdet & ~lprx, 1'b1, "normal enables");
        cmp_bit(drv, 1'b0, "no drive before low");
        i_btm_host_model.request_mode(1'b0);
        i_btm_host_model.request_mode(1'b1);
        settle(8);
        wb_xfer(1'b0, REG_STATUS, 32'h0);
        cmp_word(rd, exp_st(BTM_NORM, 1'b0, 1'b0, 1'b0, 1'b0), "glitch filtered");
        for (int i = 0; i < 8; i++)
        begin
            d = (i == 0) ? 1'b0 : 1'($urandom);
            i_btm_host_model.set_tx(1'b1, 1'b0, d);
            settle(8);
            cmp_bit(drv, 1'b1, "drive on");
            cmp_bit(plus, d, "plus line");
            cmp_bit(minus, ~d, "minus line");
        end
        set_mon(M_OT, 1'b1);
        settle(8);
        cmp_bit(drv, 1'b0, "overtemp stops drive");
        set_mon(M_OT, 1'b0);
        i_btm_host_model.set_tx(1'b1, 1'b0, 1'b0);
        settle(8);
        cmp_bit(drv, 1'b1, "drive restarts on low");
        set_mon(M_TXTO, 1'b1);
        settle(8);
        cmp_bit(drv, 1'b0, "timeout stops drive");
        set_mon(M_TXTO, 1'b0);
        i_btm_host_model.set_tx(1'b1, 1'b1, 1'b0);
        settle(8);
        cmp_bit(drv, 1'b0, "enable high idles");
        i_btm_host_model.set_tx(1'b0, 1'b0, 1'b0);
        settle(8);
        cmp_bit(drv, 1'b0, "guardian low idles");
        $display("test transmit done");

        set_mon(M_LOW, 1'b1);
        set_mon(M_ACT, 1'b1);
        settle(3);
        set_mon(M_ACT, 1'b0);
        settle(8);
        cmp_bit(rxd, 1'b1, "short activity");
        set_mon(M_ACT, 1'b1);
        settle(12);
        cmp_bit(rxd, 1'b0, "active low level");
        set_mon(M_LOW, 1'b0);
        settle(8);
        cmp_bit(rxd, 1'b1, "active high level");
        set_mon(M_LOW, 1'b1);
        set_mon(M_ACT, 1'b0);
        settle(30);
        cmp_bit(rxd, 1'b1, "idle forces high");
        set_mon(M_LOW, 1'b0);
        set_mon(M_ERR, 1'b1);
        settle(8);
        cmp_bit(err_pin_n, 1'b0, "error shown");
        set_mon(M_ERR, 1'b0);
        settle(8);
        cmp_bit(err_pin_n, 1'b1, "error clear");
        $display("test receive done");

        wb_xfer(1'b1, REG_CTRL, 32'h1);
        wb_xfer(1'b0, REG_CTRL, 32'h0);
        cmp_word(rd, 32'h1, "ctrl readback");
        settle(4);
        wb_xfer(1'b0, REG_STATUS, 32'h0);
        cmp_word(rd, exp_st(BTM_STBY, 1'b0, 1'b0, 1'b0, 1'b0), "sw standby");
        wb_xfer(1'b1, REG_CTRL, 32'h0);
        wb_xfer(1'b1, 8'h08, 32'hFF);
        i_btm_host_model.set_serial(1'b0, 1'b0);
        set_mon(M_UVIO, 1'b1);
        settle(8);
        wb_xfer(1'b0, REG_STATUS, 32'h0);
        cmp_word(rd, exp_st(BTM_STBY, 1'b0, 1'b0, 1'b1, 1'b0), "io uv standby");
        cmp_bit(rxd | err_pin_n | ro_ok, 1'b0, "io uv pins");
        cmp_bit(ser_clk_int & ser_sel_int, 1'b1, "io uv internals");
        set_mon(M_UVIO, 1'b0);
        settle(8);
        cmp_bit(ser_clk_int | ser_sel_int, 1'b0, "serial pins pass");
        wb_xfer(1'b0, REG_STATUS, 32'h0);
        cmp_word(rd, exp_st(BTM_NORM, 1'b0, 1'b0, 1'b0, 1'b0), "recover normal");
        set_mon(M_POR, 1'b0);
        settle(8);
        wb_xfer(1'b0, REG_STATUS, 32'h0);
        cmp_word({30'h0, rd[1:0]}, 32'h0, "power-off mode");
        cmp_bit(ro_ok | err_oe | nrx | lprx, 1'b0, "power-off pins");
        $display("test supply done");
        print_verdict();
    end
endmodule
